// ### rtl/spisp_pkg.sv
// spisp_pkg: constants and carrier types for the serial port
package spisp_pkg;
   localparam int BYTE_BITS = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] MODE_MASTER_TOP = 2'h0;
   localparam logic [2:0] MODE_SLAVE_TOP = 3'h2;
   localparam logic [3:0] MODE_SLAVE_NOSEL = 4'h5;
   localparam logic [1:0] CTL_CKP = 2'h0;
   // half periods stay above the four-clock input delay, or the returning bit is missed
   localparam int RATE_DIV0 = 8;
   localparam int RATE_DIV1 = 16;
   localparam int RATE_DIV2 = 32;
   localparam int CNT_W = 6;

   typedef struct packed {
      logic enable;
      logic clkIdleHigh;
      logic [3:0] mode;
      logic sampleEnd;
      logic edgeActToIdle;
   } spisp_cfg_t;

   typedef struct packed {
      logic bufferFull;
      logic writeCollision;
      logic busy;
   } spisp_stat_t;
endpackage : spisp_pkg

// ### rtl/spisp_port.sv
// spisp_port: byte-wide serial peripheral port, master or slave
`timescale 1ns/10ps
module spisp_port #(
   parameter int BUF_DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration
   input wire spisp_pkg::spisp_cfg_t cfg,
   // pin direction bits, 1 = input
   input wire logic dirIn,
   input wire logic dirOut,
   input wire logic dirClk,
   input wire logic dirSel,
   // software write to data buffer
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady,
   // received byte stream
   output logic rxValid,
   output logic [7:0] rxData,
   input wire logic rxReady,
   // status
   input wire logic collisionClear,
   output spisp_pkg::spisp_stat_t status,
   output logic serialIrq,
   // pins
   input wire logic sdiIn,
   input wire logic sckIn,
   output logic sckOut,
   output logic sckOe,
   input wire logic selIn_n,
   output logic sdoOut,
   output logic sdoOe
);
   // ----------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------
   logic [1:0] rstSync_q;
   logic rst;
   logic [2:0] sdiS_q, sckS_q, selS_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync_q <= 2'h0;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end
   assign rst = ~rstSync_q[1];

   logic sdiV_q, sckV_q, selV_q, sdiV_d, sckV_d, selV_d;
   always_comb begin
      sdiV_d = dirIn && ((sdiS_q[2] == sdiS_q[1]) ? sdiS_q[1] : sdiV_q);
      sckV_d = (sckS_q[2] == sckS_q[1]) ? sckS_q[1] : sckV_q;
      selV_d = (selS_q[2] == selS_q[1]) ? selS_q[1] : selV_q;
   end
   always_ff @(posedge clk) begin
      sdiS_q <= {sdiS_q[1:0], sdiIn};
      sckS_q <= {sckS_q[1:0], sckIn};
      selS_q <= {selS_q[1:0], selIn_n};
      sdiV_q <= rst ? 1'b0 : sdiV_d;
      sckV_q <= rst ? cfg.clkIdleHigh : sckV_d;
      selV_q <= rst ? 1'b1 : selV_d;
   end

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   logic isMaster, isSlave, useSel;
   assign isMaster = cfg.mode[3:2] == spisp_pkg::MODE_MASTER_TOP;
   assign isSlave = cfg.mode[3:1] == spisp_pkg::MODE_SLAVE_TOP;
   assign useSel = isSlave && cfg.mode != spisp_pkg::MODE_SLAVE_NOSEL && dirSel;

   // ----------------------------------------
   // two-entry receive buffer
   // ----------------------------------------
   logic [7:0] buf_q [BUF_DEPTH], buf_d [BUF_DEPTH];
   logic [1:0] cnt_q, cnt_d;
   logic pushV, pushR;
   logic [7:0] pushD;
   assign pushR = cnt_q != 2'(BUF_DEPTH);
   assign rxValid = cnt_q != 2'h0;
   assign rxData = buf_q[0];
   always_comb begin
      buf_d = buf_q;
      cnt_d = cnt_q;
      if (rxValid && rxReady) begin
         for (int i = 0; i < BUF_DEPTH - 1; i++) begin
            buf_d[i] = buf_q[i + 1];
         end
         cnt_d = cnt_d - 2'h1;
      end
      if (pushV && pushR) begin
         buf_d[cnt_d[0]] = pushD;
         cnt_d = cnt_d + 2'h1;
      end
   end

   // ----------------------------------------
   // transfer engine
   // ----------------------------------------
   typedef enum logic [1:0] {IDLE, LEAD, TRAIL, DONE} spisp_state_t;
   spisp_state_t st_q, st_d;
   logic [7:0] sh_q, sh_d;
   logic [2:0] bit_q, bit_d;
   logic [5:0] div_q, div_d;
   logic [5:0] divTop;
   logic sck_q, sck_d, sdo_q, sdo_d, write_collision_flag_q, write_collision_flag_d, irq_q, irq_d, sckPrev_q;
   logic loaded_q, loaded_d;
   logic slvLead, slvTrail, selActive, sampled_q, sampled_d;

   always_comb begin
      unique case (cfg.mode[1:0])
         2'h0: divTop = 6'(spisp_pkg::RATE_DIV0 - 1);
         2'h1: divTop = 6'(spisp_pkg::RATE_DIV1 - 1);
         default: divTop = 6'(spisp_pkg::RATE_DIV2 - 1);
      endcase
   end

   // leading edge leaves idle level
   assign slvLead = sckV_q != sckPrev_q && sckV_q != cfg.clkIdleHigh;
   assign slvTrail = sckV_q != sckPrev_q && sckV_q == cfg.clkIdleHigh;
   assign selActive = !useSel || !selV_q;
   assign txReady = st_q == IDLE && !write_collision_flag_q && cfg.enable && !loaded_q;

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      bit_d = bit_q;
      div_d = div_q;
      sck_d = sck_q;
      sdo_d = sdo_q;
      write_collision_flag_d = write_collision_flag_q;
      irq_d = 1'b0;
      pushV = 1'b0;
      pushD = sh_q;
      loaded_d = loaded_q;
      sampled_d = sampled_q;
      if (txValid && !txReady && cfg.enable) begin
         write_collision_flag_d = 1'b1;
      end else if (collisionClear) begin
         write_collision_flag_d = 1'b0;
      end
      unique case (st_q)
         IDLE: begin
            sck_d = cfg.clkIdleHigh;
            bit_d = 3'h0;
            div_d = 6'h0;
            if (txValid && txReady) begin
               sh_d = txData;
               sdo_d = txData[7];
               if (isMaster) begin
                  st_d = LEAD;
               end else begin
                  loaded_d = 1'b1;
               end
            end
            if (isSlave && selActive && slvLead) begin
               st_d = TRAIL;
               loaded_d = 1'b0;
               if (cfg.edgeActToIdle) begin
                  sampled_d = sdiV_q;
               end else begin
                  sdo_d = sh_q[7];
               end
            end
         end
         LEAD: begin
            div_d = div_q + 6'h1;
            if (div_q == divTop) begin
               div_d = 6'h0;
               sck_d = ~cfg.clkIdleHigh;
               st_d = TRAIL;
               if (!cfg.sampleEnd) begin
                  sampled_d = sdiV_q;
               end
            end
         end
         TRAIL: begin
            if (isMaster) begin
               div_d = div_q + 6'h1;
               if (div_q == divTop) begin
                  div_d = 6'h0;
                  sck_d = cfg.clkIdleHigh;
                  sh_d = {sh_q[6:0], cfg.sampleEnd ? sdiV_q : sampled_q};
                  sdo_d = sh_q[6];
                  bit_d = bit_q + 3'h1;
                  st_d = bit_q == spisp_pkg::BIT_LAST ? DONE : LEAD;
               end
            end else if (!selActive) begin
               // select cut the frame: partial byte dropped
               st_d = IDLE;
            end else if (slvLead) begin
               if (cfg.edgeActToIdle) begin
                  sampled_d = sdiV_q;
               end else begin
                  sdo_d = sh_q[7];
               end
            end else if (slvTrail) begin
               sh_d = {sh_q[6:0], cfg.edgeActToIdle ? sampled_q : sdiV_q};
               if (cfg.edgeActToIdle) begin
                  sdo_d = sh_q[6];
               end
               bit_d = bit_q + 3'h1;
               st_d = bit_q == spisp_pkg::BIT_LAST ? DONE : TRAIL;
            end
         end
         DONE: begin
            pushV = 1'b1;
            if (pushR) begin
               irq_d = 1'b1;
               st_d = IDLE;
            end
         end
      endcase
      if (!cfg.enable) begin
         st_d = IDLE;
         loaded_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= IDLE;
         sh_q <= 8'h0;
         bit_q <= 3'h0;
         div_q <= 6'h0;
         sck_q <= 1'b0;
         sdo_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         irq_q <= 1'b0;
         cnt_q <= 2'h0;
         sckPrev_q <= 1'b0;
         loaded_q <= 1'b0;
         sampled_q <= 1'b0;
         for (int i = 0; i < BUF_DEPTH; i++) begin
            buf_q[i] <= 8'h0;
         end
      end else begin
         st_q <= rst ? IDLE : st_d;
         sh_q <= sh_d;
         bit_q <= bit_d;
         div_q <= div_d;
         sck_q <= sck_d;
         sdo_q <= sdo_d;
         write_collision_flag_q <= rst ? 1'b0 : write_collision_flag_d;
         irq_q <= irq_d;
         cnt_q <= (rst || !cfg.enable) ? 2'h0 : cnt_d;
         sckPrev_q <= sckV_q;
         loaded_q <= loaded_d;
         sampled_q <= sampled_d;
         buf_q <= buf_d;
      end
   end

   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   // direction bit overrides function
   assign sckOut = sck_q;
   assign sckOe = cfg.enable && isMaster && !dirClk;
   assign sdoOut = sdo_q;
   assign sdoOe = cfg.enable && !dirOut && selActive;
   assign status = '{bufferFull: rxValid, writeCollision: write_collision_flag_q, busy: st_q != IDLE};
   assign serialIrq = irq_q;
endmodule : spisp_port

// ### tb/spisp_props.sv
// spisp_props: port checker for the serial port
`timescale 1ns/10ps
module spisp_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // watched ports
   input wire spisp_pkg::spisp_cfg_t cfg,
   input wire logic dirOut,
   input wire logic txValid,
   input wire logic txReady,
   input wire logic rxValid,
   input wire logic collisionClear,
   input wire spisp_pkg::spisp_stat_t status,
   input wire logic serialIrq,
   input wire logic sckOe,
   input wire logic sdoOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_off_no_drive: assert property (!cfg.enable |-> !sckOe && !sdoOe)
      else $error("pins driven while off");
   a_slave_no_clk: assert property (cfg.mode[3:2] == 2'h1 |-> !sckOe)
      else $error("slave drives clock");
   a_dir_blocks_out: assert property (dirOut |-> !sdoOe)
      else $error("data out driven against direction");
   a_irq_means_full: assert property (serialIrq |-> ##[0:2] rxValid)
      else $error("flag without received byte");
   a_irq_one_cycle: assert property (serialIrq |=> !serialIrq)
      else $error("flag longer than a cycle");
   a_refused_sets_col: assert property (cfg.enable && txValid && status.busy |=> status.writeCollision)
      else $error("busy write left no collision");
   a_col_holds: assert property (status.writeCollision && !collisionClear && cfg.enable |=> status.writeCollision)
      else $error("collision dropped uncleared");
   a_col_blocks_wr: assert property (status.writeCollision |-> !txReady)
      else $error("write open under collision");
   a_byte_not_short: assert property ($rose(status.busy) |-> (status.busy || !cfg.enable) [*8])
      else $error("transfer too short");
   c_byte_done: cover property (serialIrq);
   c_collision: cover property ($rose(status.writeCollision));
   c_abort: cover property ($fell(cfg.enable) && status.busy);
endmodule : spisp_props

bind spisp_port spisp_props i_spisp_props (.clk(clk), .rst_n(rst_n), .cfg(cfg), .dirOut(dirOut),
   .txValid(txValid), .txReady(txReady), .rxValid(rxValid), .collisionClear(collisionClear),
   .status(status), .serialIrq(serialIrq), .sckOe(sckOe), .sdoOe(sdoOe));

// ### tb/spisp_far_end.sv
// spisp_far_end: far-side peer, slave to our master or master to our slave
`timescale 1ns/10ps
module spisp_far_end (
   // pins
   input wire logic sckOut,
   input wire logic sckOe,
   input wire logic sdoOut,
   input wire logic sdoOe,
   output logic sckIn,
   output logic sdiIn,
   output logic selIn_n,
   // bench side
   input wire logic cpol,
   input wire logic load,
   input wire logic [7:0] txByte,
   output logic [7:0] rxByte
);
   logic [7:0] shift = 8'h00;
   logic sck;
   initial sckIn = 1'b0;
   initial selIn_n = 1'b1;
   initial rxByte = 8'h00;
   assign sck = (sckOe ? sckOut : sckIn) ^ cpol;
   assign sdiIn = shift[7];
   always @(posedge load) shift = txByte;
   // msb first; stale bits inverted so nothing passes by luck
   always @(negedge sck) shift = {shift[6:0], ~shift[0]};
   // as slave it samples mid-bit; as master at bit end, since the port answers clocks late
   always @(posedge sck) if (sckOe) rxByte = {rxByte[6:0], sdoOe ? sdoOut : ~rxByte[0]};
   always @(negedge sck) if (!sckOe) rxByte = {rxByte[6:0], sdoOe ? sdoOut : ~rxByte[0]};
   task automatic burst();
      selIn_n = 1'b0;
      repeat (8) begin
         #160 sckIn = 1'b1;
         #160 sckIn = 1'b0;
      end
      // let the last edge pass the port's input delay before deselecting
      #160;
      selIn_n = 1'b1;
   endtask : burst
endmodule : spisp_far_end

// ### tb/spisp_port_tb.sv
// spisp_port_tb: directed bench for the serial port
`timescale 1ns/10ps
module spisp_port_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic dirIn = 1'b1, dirOut = 1'b0, dirClk = 1'b0, dirSel = 1'b1;
   logic txValid = 1'b0, rxReady = 1'b0, collisionClear = 1'b0, load = 1'b0;
   logic txReady, rxValid, serialIrq, sdiIn, sckIn, sckOut, sckOe, selIn_n, sdoOut, sdoOe;
   logic [7:0] txData = 8'h00, farTx = 8'h00;
   logic [7:0] rxData, farRx;
   spisp_pkg::spisp_cfg_t cfg = '{enable: 1'b0, clkIdleHigh: 1'b0, mode: 4'h0, sampleEnd: 1'b0, edgeActToIdle: 1'b1};
   spisp_pkg::spisp_stat_t status;
   int bad_count = 0, total_checks = 0, cyc;
   int divs[4] = '{spisp_pkg::RATE_DIV0, spisp_pkg::RATE_DIV1, spisp_pkg::RATE_DIV2, spisp_pkg::RATE_DIV2};
   always #20 clk = ~clk;
   spisp_port i_spisp_port (.clk(clk), .rst_n(rst_n), .cfg(cfg), .dirIn(dirIn), .dirOut(dirOut), .dirClk(dirClk),
      .dirSel(dirSel), .txValid(txValid), .txData(txData), .txReady(txReady), .rxValid(rxValid), .rxData(rxData),
      .rxReady(rxReady), .collisionClear(collisionClear), .status(status), .serialIrq(serialIrq), .sdiIn(sdiIn),
      .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .selIn_n(selIn_n), .sdoOut(sdoOut), .sdoOe(sdoOe));
   spisp_far_end i_spisp_far_end (.sckOut(sckOut), .sckOe(sckOe), .sdoOut(sdoOut), .sdoOe(sdoOe), .sckIn(sckIn),
      .sdiIn(sdiIn), .selIn_n(selIn_n), .cpol(cfg.clkIdleHigh), .load(load), .txByte(farTx), .rxByte(farRx));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic setup(input logic [3:0] m, input logic idle, input logic smp);
      @(negedge clk) cfg.enable = 1'b0;
      cfg.mode = m;
      cfg.clkIdleHigh = idle;
      cfg.sampleEnd = smp;
      @(negedge clk) cfg.enable = 1'b1;
      repeat (3) @(negedge clk);
   endtask : setup
   task automatic put(input logic [7:0] b);
      @(negedge clk) txValid = 1'b1;
      txData = b;
      @(negedge clk) txValid = 1'b0;
   endtask : put
   // read each byte before the next write
   task automatic wait_rx(input logic [7:0] exp);
      cyc = 0;
      while (rxValid !== 1'b1 && cyc < 3000) begin
         @(negedge clk);
         cyc++;
      end
      chk(rxData, exp);
      chk({7'h0, status.bufferFull}, 8'h01);
      rxReady = 1'b1;
      @(negedge clk) rxReady = 1'b0;
      chk({7'h0, status.bufferFull}, 8'h00);
   endtask : wait_rx
   task automatic xfer(input logic [7:0] tx, input logic [7:0] far, input logic slv);
      farTx = far;
      load = 1'b1;
      @(negedge clk) load = 1'b0;
      put(tx);
      if (slv) i_spisp_far_end.burst();
      wait_rx(far);
      chk(farRx, tx);
   endtask : xfer
   initial begin
      #400000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      for (int m = 0; m < 4; m++) begin
         setup(4'(m), 1'b0, 1'b0);
         xfer(8'hA5 ^ 8'(m), 8'h3C + 8'(m), 1'b0);
         chk({7'h0, cyc >= 16 * divs[m] - 2 && cyc <= 16 * divs[m] + 24}, 8'h01);
      end
      setup(4'h1, 1'b1, 1'b1);
      xfer(8'h4B, 8'hD2, 1'b0);
      setup(4'h4, 1'b0, 1'b0);
      xfer(8'h1E, 8'hB4, 1'b1);
      setup(spisp_pkg::MODE_SLAVE_NOSEL, 1'b0, 1'b0);
      xfer(8'hC3, 8'h69, 1'b1);
      // slow rate leaves time to write into a running byte
      setup(4'h2, 1'b0, 1'b0);
      farTx = 8'h96;
      load = 1'b1;
      put(8'h5A);
      load = 1'b0;
      put(8'hFF);
      chk({7'h0, status.writeCollision}, 8'h01);
      wait_rx(8'h96);
      chk(farRx, 8'h5A);
      put(8'h11);
      @(negedge clk);
      chk({7'h0, status.busy}, 8'h00);
      collisionClear = 1'b1;
      @(negedge clk) collisionClear = 1'b0;
      chk({7'h0, status.writeCollision}, 8'h00);
      put(8'h22);
      repeat (40) @(negedge clk);
      dirOut = 1'b1;
      @(negedge clk);
      chk({7'h0, sdoOe}, 8'h00);
      cfg.enable = 1'b0;
      @(negedge clk);
      chk({6'h0, status.busy, rxValid}, 8'h00);
      chk({7'h0, sckOe}, 8'h00);
      // reset in mid-byte
      dirOut = 1'b0;
      setup(4'h1, 1'b0, 1'b0);
      put(8'h33);
      repeat (20) @(negedge clk);
      chk({7'h0, status.busy}, 8'h01);
      rst_n = 1'b0;
      @(negedge clk);
      chk({6'h0, status.busy, sckOut}, 8'h00);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk({7'h0, status.busy}, 8'h00);
      report_and_stop();
   end
endmodule : spisp_port_tb
